// [design/cable_phy_datapath.sv]
// cable data path: link parallel interface, data-strobe serdes, line monitors
`timescale 1ns/10ps

module word_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } fifo_type;
    fifo_type f_reg;
    fifo_type f_next;
    logic     push;
    logic     pop;

    assign in_ready  = (f_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (f_reg.cnt != '0);
    assign out_data  = f_reg.mem[f_reg.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        f_next = f_reg;
        if (push) begin
            f_next.mem[f_reg.wr] = in_data;
            f_next.wr = (f_reg.wr == AW'(DEPTH-1)) ? '0 : f_reg.wr + 1'b1;
        end
        if (pop) begin
            f_next.rd = (f_reg.rd == AW'(DEPTH-1)) ? '0 : f_reg.rd + 1'b1;
        end
        f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end
endmodule : word_fifo

module cable_phy_datapath
    import cable_phy_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       power_down_pin,
    input  wire logic       iso_n,
    output logic            pll_run,
    output logic            sysclk_out,
    input  wire logic [7:0] tx_data,
    input  wire logic [1:0] tx_speed,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            tpa_out,
    output logic            tpa_oe_n,
    input  wire logic       tpa_in,
    output logic            tpb_out,
    output logic            tpb_oe_n,
    input  wire logic       tpb_in,
    input  wire logic       arb_active,
    input  wire logic [1:0] tpa_line,
    input  wire logic [1:0] tpb_line,
    input  wire logic [1:0] tpa_cm_speed,
    input  wire logic       tpb_bias_in,
    output logic [3:0]      arb_status,
    output logic [1:0]      next_speed,
    output logic            connected
);
    typedef struct packed {
        mode_type   mode;
        logic [2:0] div;
        logic       sysclk;
        logic [1:0] hold;
        logic [7:0] tx_shift;
        logic [3:0] tx_left;
        logic [1:0] tx_spd;
        logic       ds_data;
        logic       ds_strobe;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [4:0] quiet;
        logic [1:0] rx_spd;
        logic [7:0] rx_shift;
        logic [3:0] rx_cnt;
        logic [7:0] rx_word;
        logic       rx_word_ok;
        logic [7:0] rx_plain;
        logic       rx_plain_ok;
        logic [7:0] link_data;
        logic       link_valid;
        logic [3:0] arb;
        logic [1:0] speed;
        logic       bias;
    } state_type;

    state_type  s_reg;
    state_type  s_next;
    logic       tick;
    logic       fifo_in_valid;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    logic [9:0] fifo_out;
    logic       line_change;

    // word latch point, once per system clock period
    assign tick          = (s_reg.div == SYS_DIV_LAST) && (s_reg.mode != ST_DOWN);
    assign fifo_in_valid = tx_valid && tick && !power_down_pin;
    assign line_change   = (s_reg.sync2 != s_reg.prev);
    // next word only once the last bit has held its full period
    assign fifo_out_ready = (s_reg.mode == ST_IDLE || s_reg.mode == ST_TX) && (s_reg.tx_left == 4'h0)
                            && (s_reg.hold == 2'h0) && !power_down_pin;

    word_fifo #(
        .WIDTH (WORD_W + 2),
        .DEPTH (FIFO_DEPTH)
    ) tx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   ({tx_speed, tx_data}),
        .in_valid  (fifo_in_valid),
        .in_ready  (tx_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );

    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = {tpa_in, tpb_in};
        s_next.sync2 = s_reg.sync1;
        s_next.prev  = s_reg.sync2;
        s_next.bias  = tpb_bias_in;
        if (arb_active) begin
            s_next.arb   = {tpa_line, tpb_line};
            s_next.speed = tpa_cm_speed;
        end
        // system clock divided from the bit reference
        s_next.div    = (s_reg.div == SYS_DIV_LAST) ? 3'h0 : s_reg.div + 3'h1;
        s_next.sysclk = (s_next.div >= SYS_DIV_HIGH);

        // hand the finished word to the link on the system clock; a word that completes now wins
        if (tick) begin
            s_next.rx_plain_ok = s_reg.rx_word_ok;
            if (s_reg.rx_word_ok) begin
                s_next.rx_plain = s_reg.rx_word;
            end
            s_next.rx_word_ok = 1'b0;
            // differentiated outputs only carry edges, so a barrier can couple them
            if (iso_n) begin
                s_next.link_data  = s_next.rx_plain;
                s_next.link_valid = s_next.rx_plain_ok;
            end else begin
                s_next.link_data  = s_next.rx_plain ^ s_reg.rx_plain;
                s_next.link_valid = s_next.rx_plain_ok ^ s_reg.rx_plain_ok;
            end
        end

        case (s_reg.mode)
            ST_IDLE: begin
                if (fifo_out_valid) begin
                    s_next.mode = ST_TX;
                end else if (line_change) begin
                    s_next.mode     = ST_RX;
                    s_next.rx_spd   = s_reg.speed;
                    s_next.rx_cnt   = 4'h0;
                    s_next.rx_shift = 8'h00;
                    s_next.quiet    = 5'h0;
                end
            end
            ST_TX: begin
                if (s_reg.hold != 2'h0) begin
                    s_next.hold = s_reg.hold - 2'h1;
                end else if (s_reg.tx_left != 4'h0) begin
                    // strobe toggles only when data repeats
                    s_next.ds_data   = s_reg.tx_shift[0];
                    s_next.ds_strobe = s_reg.ds_strobe ^ (s_reg.tx_shift[0] == s_reg.ds_data);
                    s_next.tx_shift  = {1'b0, s_reg.tx_shift[7:1]};
                    s_next.tx_left   = s_reg.tx_left - 4'h1;
                    // speed of the word in the shifter, the fifo head already shows the next one
                    s_next.hold      = bit_hold(s_reg.tx_spd);
                end else if (!fifo_out_valid) begin
                    s_next.mode = ST_IDLE;
                end
            end
            ST_RX: begin
                if (line_change) begin
                    // any edge on data or strobe marks one bit; data is its value
                    s_next.quiet = 5'h0;
                    s_next.rx_shift[s_reg.rx_cnt[2:0]] = s_reg.sync2[1];
                    if (s_reg.rx_cnt + 4'h1 == lines_of(s_reg.rx_spd)) begin
                        s_next.rx_word    = s_next.rx_shift & line_mask(s_reg.rx_spd);
                        s_next.rx_word_ok = 1'b1;
                        s_next.rx_cnt     = 4'h0;
                        s_next.rx_shift   = 8'h00;
                    end else begin
                        s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                    end
                end else if (s_reg.quiet == RX_QUIET_LAST) begin
                    s_next.mode = ST_IDLE;
                end else begin
                    s_next.quiet = s_reg.quiet + 5'h1;
                end
            end
            ST_DOWN: begin
                if (!power_down_pin) begin
                    s_next.mode = ST_IDLE;
                end
            end
            default: begin
                s_next.mode = ST_IDLE;
            end
        endcase

        // the fifo pop and the shifter load happen in the same cycle
        if (fifo_out_valid && fifo_out_ready) begin
            s_next.mode     = ST_TX;
            s_next.tx_shift = fifo_out[7:0] & line_mask(fifo_out[9:8]);
            s_next.tx_left  = lines_of(fifo_out[9:8]);
            s_next.tx_spd   = fifo_out[9:8];
            s_next.hold     = 2'h0;
        end

        // power-down enters ST_DOWN and freezes the rest of the state but clears the divider, system clock, bit count, hold and link outputs
        if (power_down_pin) begin
            s_next            = s_reg;
            s_next.mode       = ST_DOWN;
            s_next.div        = 3'h0;
            s_next.sysclk     = 1'b0;
            s_next.tx_left    = 4'h0;
            s_next.hold       = 2'h0;
            s_next.link_data  = 8'h00;
            s_next.link_valid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg      <= '0;
            s_reg.mode <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pll_run    = (s_reg.mode != ST_DOWN);
    assign sysclk_out = s_reg.sysclk;
    assign rx_data    = s_reg.link_data;
    assign rx_valid   = s_reg.link_valid;
    assign tpb_out    = s_reg.ds_data;
    assign tpa_out    = s_reg.ds_strobe;
    assign tpa_oe_n   = (s_reg.mode != ST_TX);
    assign tpb_oe_n   = (s_reg.mode != ST_TX);
    assign arb_status = s_reg.arb;
    assign next_speed = s_reg.speed;
    assign connected  = s_reg.bias;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sys_tick_s;
        tick && !power_down_pin;
    endsequence
    sequence arb_window_s;
        arb_active && !power_down_pin;
    endsequence

    drivers_tx_only_a: assert property ((!$stable(tpb_out) || !$stable(tpa_out)) |-> !tpa_oe_n && !tpb_oe_n)
        else $error("line changed with drivers off");
    rx_drivers_off_a: assert property ((s_reg.mode == ST_IDLE) && line_change && !fifo_out_valid
        && !power_down_pin |=> (s_reg.mode == ST_RX) && tpa_oe_n && tpb_oe_n)
        else $error("driver on during reception");
    ds_one_edge_a: assert property (!$stable(tpb_out) |-> $stable(tpa_out))
        else $error("data and strobe changed together");
    sysclk_period_a: assert property (disable iff (rst || power_down_pin)
        $rose(sysclk_out) |-> !$past(sysclk_out, 4) ##1 sysclk_out [*3] ##1 !sysclk_out)
        else $error("system clock period wrong");
    pd_halt_a: assert property (power_down_pin |=> !pll_run && !sysclk_out && tpa_oe_n)
        else $error("power-down did not halt");
    iso_plain_a: assert property ((sys_tick_s and iso_n) |=> rx_data == s_reg.rx_plain)
        else $error("plain output differs from word");
    iso_diff_a: assert property ((sys_tick_s and !iso_n) |=> rx_data == (s_reg.rx_plain ^ $past(s_reg.rx_plain)))
        else $error("differentiated output wrong");
    arb_state_a: assert property (arb_window_s |=> arb_status == $past({tpa_line, tpb_line}))
        else $error("arbitration status not from comparators");
    arb_speed_a: assert property (arb_window_s |=> next_speed == $past(tpa_cm_speed))
        else $error("next speed not from common mode");
    conn_bias_a: assert property (!power_down_pin |=> connected == $past(tpb_bias_in))
        else $error("connection flag not from bias");
endmodule : cable_phy_datapath

// [design/cable_phy_pkg.sv]
// constants shared by the cable data path
package cable_phy_pkg;
    // rates in MHz as printed
    localparam real CLK_MHZ          = 125.0;
    localparam real REF_MHZ          = 393.216;
    localparam real XTAL_MHZ         = 24.576;
    localparam real SYSCLK_MHZ       = 49.152;
    localparam int  REF_PER_SYSCLK   = int'(REF_MHZ / SYSCLK_MHZ);
    // one reference cycle per clk edge, so one system clock period spans REF_PER_SYSCLK clk edges; the divider's last count is one less
    localparam logic [2:0] SYS_DIV_LAST  = 3'(REF_PER_SYSCLK - 1);
    localparam logic [2:0] SYS_DIV_HIGH  = 3'h4;
    localparam logic [4:0] RX_QUIET_LAST = 5'h1f;
    localparam int  FIFO_DEPTH       = 4;
    localparam int  WORD_W           = 8;

    // speed grades
    localparam logic [1:0] SPD_S100 = 2'h0;
    localparam logic [1:0] SPD_S200 = 2'h1;
    localparam logic [1:0] SPD_S400 = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_TX   = 4'h2,
        ST_RX   = 4'h4,
        ST_DOWN = 4'h8
    } mode_type;

    // lines used per speed
    function automatic logic [3:0] lines_of(input logic [1:0] spd);
        case (spd)
            SPD_S100: lines_of = 4'h2;
            SPD_S200: lines_of = 4'h4;
            default:  lines_of = 4'h8;
        endcase
    endfunction : lines_of

    // extra clk edges each serial bit is held, one less than the clk edges per bit
    function automatic logic [1:0] bit_hold(input logic [1:0] spd);
        case (spd)
            SPD_S100: bit_hold = 2'h3;
            SPD_S200: bit_hold = 2'h1;
            default:  bit_hold = 2'h0;
        endcase
    endfunction : bit_hold

    function automatic logic [7:0] line_mask(input logic [1:0] spd);
        case (spd)
            SPD_S100: line_mask = 8'h03;
            SPD_S200: line_mask = 8'h0f;
            default:  line_mask = 8'hff;
        endcase
    endfunction : line_mask
endpackage : cable_phy_pkg

// [verification/cable_remote_node.sv]
// remote cable node: data-strobe sender and capture of the transmitted stream
`timescale 1ns/10ps
module cable_remote_node (
    input  wire logic clk,
    input  wire logic tpa_out,
    input  wire logic tpb_out,
    input  wire logic tpa_oe_n,
    input  wire logic tpb_oe_n,
    output logic      tpa_in,
    output logic      tpb_in
);
    logic seen_a;
    logic seen_b;
    logic tx_bits[$];

    initial begin
        tpa_in = 1'b0;
        tpb_in = 1'b0;
        seen_a = 1'b0;
        seen_b = 1'b0;
    end

    // every line change while both drivers are on carries one bit
    always @(posedge clk) begin
        if (!tpa_oe_n && !tpb_oe_n && {tpa_out, tpb_out} !== {seen_a, seen_b}) begin
            tx_bits.push_back(tpb_out);
        end
        seen_a <= tpa_out;
        seen_b <= tpb_out;
    end

    // lines are held, not released, between bits: a change would be a bit
    task automatic send_word(input logic [7:0] d, input int n);
        @(negedge clk);
        tpb_in = ~tpb_in;
        repeat (3) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            if (d[i] === tpa_in) tpb_in = ~tpb_in;
            else tpa_in = d[i];
            repeat (3) @(negedge clk);
        end
    endtask : send_word
endmodule : cable_remote_node

// [verification/cable_phy_datapath_test.sv]
// self-checking bench for the cable data path
`timescale 1ns/10ps
module cable_phy_datapath_test;
    import cable_phy_pkg::*;
    logic       clk, rst, power_down_pin, iso_n, pll_run, sysclk_out, tx_valid, tx_ready, rx_valid;
    logic       tpa_out, tpa_oe_n, tpa_in, tpb_out, tpb_oe_n, tpb_in, arb_active, tpb_bias_in, connected;
    logic [7:0] tx_data, rx_data;
    logic [1:0] tx_speed, tpa_line, tpb_line, tpa_cm_speed, next_speed;
    logic [3:0] arb_status;
    int         fails, n_checks, cyc, rxv_hi;

    cable_phy_datapath DUT (.clk(clk), .rst(rst), .power_down_pin(power_down_pin), .iso_n(iso_n),
        .pll_run(pll_run), .sysclk_out(sysclk_out), .tx_data(tx_data), .tx_speed(tx_speed),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .tpa_out(tpa_out), .tpa_oe_n(tpa_oe_n), .tpa_in(tpa_in), .tpb_out(tpb_out), .tpb_oe_n(tpb_oe_n),
        .tpb_in(tpb_in), .arb_active(arb_active), .tpa_line(tpa_line), .tpb_line(tpb_line),
        .tpa_cm_speed(tpa_cm_speed), .tpb_bias_in(tpb_bias_in), .arb_status(arb_status),
        .next_speed(next_speed), .connected(connected));
    cable_remote_node remote (.clk(clk), .tpa_out(tpa_out), .tpb_out(tpb_out), .tpa_oe_n(tpa_oe_n),
        .tpb_oe_n(tpb_oe_n), .tpa_in(tpa_in), .tpb_in(tpb_in));

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1) rxv_hi <= rxv_hi + 1;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end

    // held across one tick; caller lowers tx_valid after the last word
    task automatic push_word(input logic [7:0] d);
        tx_data = d;
        tx_valid = 1'b1;
        @(negedge sysclk_out);
        @(negedge clk);
    endtask : push_word

    task automatic t_clk;
        int   hi;
        int   rises;
        logic last;
        hi = 0;
        rises = 0;
        last = sysclk_out;
        repeat (64) begin
            @(negedge clk);
            if (sysclk_out === 1'b1) hi++;
            if (sysclk_out === 1'b1 && last === 1'b0) rises++;
            last = sysclk_out;
        end
        check(hi == 32 && rises == 8, "sysclk not clk/8");
        $display("clock test done");
    endtask : t_clk

    task automatic t_tx(input logic [1:0] spd, input logic [7:0] d0, input logic [7:0] d1);
        int          n;
        logic [15:0] exp;
        logic [15:0] got;
        n = 2 << spd;
        exp = 16'h0;
        got = 16'h0;
        for (int i = 0; i < n; i++) begin
            exp[i] = d0[i];
            exp[n + i] = d1[i];
        end
        remote.tx_bits.delete();
        tx_speed = spd;
        push_word(d0);
        push_word(d1);
        tx_valid = 1'b0;
        repeat (24) @(negedge clk);
        check(remote.tx_bits.size() == 2 * n, "tx bit count");
        foreach (remote.tx_bits[i]) if (i < 16) got[i] = remote.tx_bits[i];
        check(got === exp, "tx bits");
        check(tpa_oe_n === 1'b1 && tpb_oe_n === 1'b1, "drivers left on");
        $display("tx test done");
    endtask : t_tx

    task automatic t_rx(input logic [1:0] spd, input logic [7:0] d);
        int         n;
        logic [7:0] exp;
        n = 2 << spd;
        exp = d & ((8'h1 << n) - 8'h1);
        tpa_cm_speed = spd;
        repeat (2) @(negedge clk);
        check(next_speed === spd, "next speed");
        rxv_hi = 0;
        remote.send_word(d, n);
        check(tpa_oe_n === 1'b1 && tpb_oe_n === 1'b1, "drivers on in rx");
        for (int i = 0; i < 20 && rx_valid !== 1'b1; i++) @(negedge clk);
        check(rx_valid === 1'b1 && rx_data === exp, "rx word");
        repeat (40) @(negedge clk);
        check(rxv_hi == 8, "rx valid length");
        $display("rx test done");
    endtask : t_rx

    task automatic t_iso;
        iso_n = 1'b0;
        rxv_hi = 0;
        remote.send_word(8'h11, 8);
        for (int i = 0; i < 20 && rx_valid !== 1'b1; i++) @(negedge clk);
        check(rx_data === (8'h11 ^ 8'hb4), "edge data");
        repeat (30) @(negedge clk);
        check(rxv_hi == 16, "valid edge pair");
        iso_n = 1'b1;
        repeat (40) @(negedge clk);
        $display("isolation test done");
    endtask : t_iso

    task automatic t_mon;
        for (int v = 0; v < 16; v += 5) begin
            {tpa_line, tpb_line} = 4'(v);
            tpb_bias_in = v[0];
            repeat (2) @(negedge clk);
            check(arb_status === 4'(v), "arb status");
            check(connected === v[0], "connected");
        end
        arb_active = 1'b0;
        {tpa_line, tpb_line} = 4'h0;
        repeat (2) @(negedge clk);
        check(arb_status === 4'hf, "arb not frozen");
        $display("monitor test done");
    endtask : t_mon

    task automatic t_pdown;
        int k;
        k = 0;
        remote.tx_bits.delete();
        power_down_pin = 1'b1;
        tx_data = 8'hff;
        tx_valid = 1'b1;
        repeat (2) @(negedge clk);
        check(pll_run === 1'b0, "pll still running");
        repeat (16) begin
            @(negedge clk);
            if (sysclk_out !== 1'b0) k++;
        end
        check(k == 0 && remote.tx_bits.size() == 0 && tpb_oe_n === 1'b1, "not halted");
        tx_valid = 1'b0;
        power_down_pin = 1'b0;
        repeat (2) @(negedge clk);
        check(pll_run === 1'b1, "pll not restarted");
        $display("power down test done");
    endtask : t_pdown

    initial begin
        fails = 0;
        n_checks = 0;
        cyc = 0;
        rxv_hi = 0;
        rst = 1'b1;
        power_down_pin = 1'b0;
        iso_n = 1'b1;
        tx_data = 8'h00;
        tx_speed = SPD_S100;
        tx_valid = 1'b0;
        arb_active = 1'b1;
        tpa_line = 2'h0;
        tpb_line = 2'h0;
        tpa_cm_speed = SPD_S100;
        tpb_bias_in = 1'b0;
        repeat (8) @(negedge clk);
        check(tpa_oe_n === 1'b1 && tpb_oe_n === 1'b1 && pll_run === 1'b1 && tx_ready === 1'b1, "reset");
        rst = 1'b0;
        t_clk();
        t_tx(SPD_S100, 8'hfd, 8'h02);
        t_tx(SPD_S200, 8'h3a, 8'hc5);
        t_tx(SPD_S400, 8'ha5, 8'h3c);
        t_rx(SPD_S100, 8'hfe);
        t_rx(SPD_S200, 8'h59);
        t_rx(SPD_S400, 8'hb4);
        t_iso();
        t_mon();
        t_pdown();
        finish_test();
    end
endmodule : cable_phy_datapath_test
